// ===== shared/pwmart_defines.vh
// Operation
// - Enable bit low freezes prescaler and counter; high lets counter run.
// - Force-reload bit is write-only and always reads back as zero.
// - Writing force-reload loads reload value into counter and clears prescaler.
// - Overflow interrupt request is flag AND overflow interrupt enable.
// - Overflow from FFh sets flag; reading control/status register clears it.
// - Counter access register reads or writes the live counter while running.
// - Every overflow loads the reload value into the counter.
// - At the overflow reload each output takes its polarity-given level.
// - Each output-enable bit connects or disconnects its channel's pin.
// - Polarity 0 gives 1 while counter <= compare, else 0; 1 inverts.
// - Changing a polarity bit inverts that output at once.
// - Duty sets each channel's second edge; first edge is the common reload.
// - Two upper capture control/status bits are reserved and read zero.
// - Edge-select bit 0 captures on falling edge, 1 on rising edge.
// - Each capture channel has its own interrupt enable gating its flag.
// - Capture sets channel flag; reading its capture data register clears it.
// - Capture data register holds counter value of the first capture after its flag was last cleared.
// - Every register resets to zero.
// - Divider field divides the prescaler by two to the field value.
// - Clock select 0 uses CPU clock, 1 uses external clock input.
// - Hidden compare registers load from duty registers only at overflow.
// - At compare match the output returns to the level opposite overflow.
`ifndef PWMART_DEFINES_VH
`define PWMART_DEFINES_VH

// Register indexes, byte address is four times the index
`define PWMART_IDX_DUTY3 8'h73
`define PWMART_IDX_DUTY2 8'h74
`define PWMART_IDX_DUTY1 8'h75
`define PWMART_IDX_DUTY0 8'h76
`define PWMART_IDX_PWMCTL 8'h77
`define PWMART_IDX_CSR 8'h78
`define PWMART_IDX_CAR 8'h79
`define PWMART_IDX_ARR 8'h7a
`define PWMART_IDX_ICCSR 8'h7b
`define PWMART_IDX_CAPT1 8'h7c
`define PWMART_IDX_CAPT2 8'h7d

// Control/status fields
`define PWMART_CSR_EXTERNAL_CLOCK_SELECT 7
`define PWMART_CSR_CC_HI 6
`define PWMART_CSR_CC_LO 4
`define PWMART_CSR_TCE 3
`define PWMART_CSR_FORCE_RELOAD 2
`define PWMART_CSR_OIE 1
`define PWMART_CSR_OVF 0

// PWM control fields
`define PWMART_PCR_OE_HI 7
`define PWMART_PCR_OE_LO 4
`define PWMART_PCR_OP_HI 3
`define PWMART_PCR_OP_LO 0

// Capture control/status fields
`define PWMART_ICS_CS_HI 5
`define PWMART_ICS_CS_LO 4
`define PWMART_ICS_CIE_HI 3
`define PWMART_ICS_CIE_LO 2

// Values and widths
`define PWMART_RST_VAL 8'h00
`define PWMART_CNT_TOP 8'hff
`define PWMART_ADDR_W 12

`endif

// ===== verilog/pwmart_timer.v
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "pwmart_defines.vh"

module pwmart_timer
(
  input wire clk,
  input wire rst,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PWMART_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire [31:0] prdata,
  output wire pslverr,
  input wire ext_clock_pin,
  input wire [1:0] capture_input_pin,
  output wire [3:0] pwm_output_pin,
  output wire [3:0] pwm_pin_drive,
  output wire overflow_irq,
  output wire [1:0] capture_irq
);

  // Register index match, upper address bits must be zero
  function hit;
    input [`PWMART_ADDR_W-1:0] a;
    input [7:0] i;
    begin
      hit = (a[`PWMART_ADDR_W-1:2] == {2'b00, i});
    end
  endfunction

  reg [7:0] duty_q [0:3];
  reg [7:0] hidden_compare_q [0:3];
  reg [7:0] pwm_output_control_q;
  reg external_clock_select_q;
  reg [2:0] clock_divider_field_q;
  reg counter_run_enable_q;
  reg overflow_irq_enable_q;
  reg overflow_flag_q;
  reg [7:0] cnt_q;
  reg [6:0] presc_q;
  reg [7:0] reload_value_q;
  reg [1:0] capture_edge_sel_q;
  reg [1:0] capture_irq_enables_q;
  reg [1:0] capture_flags_q;
  reg [7:0] capture_data_q [0:1];
  reg [31:0] prdata_q;
  reg ovf_seen_q;
  reg [1:0] cf_seen_q;
  reg [3:0] pwm_q;
  reg [2:0] ext_sync_q;
  reg [2:0] cap_sync0_q;
  reg [2:0] cap_sync1_q;
  reg [31:0] rd_mux;
  reg mapped;

  wire wr_acc = psel & penable & pwrite & ce;
  wire rd_setup = psel & ~penable & ~pwrite & ce;
  wire rd_acc = psel & penable & ~pwrite & ce;

  wire csr_wr = wr_acc & hit(paddr, `PWMART_IDX_CSR);
  wire car_wr = wr_acc & hit(paddr, `PWMART_IDX_CAR);
  wire force_reload_wr = csr_wr & pwdata[`PWMART_CSR_FORCE_RELOAD];

  // External clock rising edge after two-stage synchroniser
  wire ext_rise = ext_sync_q[1] & ~ext_sync_q[2];
  wire tick = external_clock_select_q ? ext_rise : 1'b1;
  wire [6:0] div_mask = ~(7'h7f << clock_divider_field_q);
  wire step = counter_run_enable_q & tick &
    ((presc_q & div_mask) == div_mask);
  wire ovf_evt = step & (cnt_q == `PWMART_CNT_TOP) & ~car_wr & ~force_reload_wr;

  assign pready = ce;
  assign prdata = prdata_q;
  assign pslverr = psel & penable & ~mapped;
  assign overflow_irq = overflow_flag_q & overflow_irq_enable_q;
  assign capture_irq = capture_flags_q & capture_irq_enables_q;
  assign pwm_output_pin = pwm_q;
  assign pwm_pin_drive =
    pwm_output_control_q[`PWMART_PCR_OE_HI:`PWMART_PCR_OE_LO];

  // Address decode and read data
  always @*
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    if (hit(paddr, `PWMART_IDX_DUTY3))
      rd_mux[7:0] = duty_q[3];
    else if (hit(paddr, `PWMART_IDX_DUTY2))
      rd_mux[7:0] = duty_q[2];
    else if (hit(paddr, `PWMART_IDX_DUTY1))
      rd_mux[7:0] = duty_q[1];
    else if (hit(paddr, `PWMART_IDX_DUTY0))
      rd_mux[7:0] = duty_q[0];
    else if (hit(paddr, `PWMART_IDX_PWMCTL))
      rd_mux[7:0] = pwm_output_control_q;
    else if (hit(paddr, `PWMART_IDX_CSR))
      rd_mux[7:0] = {external_clock_select_q, clock_divider_field_q,
        counter_run_enable_q, 1'b0, overflow_irq_enable_q,
        overflow_flag_q};
    else if (hit(paddr, `PWMART_IDX_CAR))
      rd_mux[7:0] = cnt_q;
    else if (hit(paddr, `PWMART_IDX_ARR))
      rd_mux[7:0] = reload_value_q;
    else if (hit(paddr, `PWMART_IDX_ICCSR))
      rd_mux[7:0] = {2'b00, capture_edge_sel_q, capture_irq_enables_q,
        capture_flags_q};
    else if (hit(paddr, `PWMART_IDX_CAPT1))
      rd_mux[7:0] = capture_data_q[0];
    else if (hit(paddr, `PWMART_IDX_CAPT2))
      rd_mux[7:0] = capture_data_q[1];
    else
      mapped = 1'b0;
  end

  // Read data latched in setup, flags seen there are the ones cleared
  always @(posedge clk)
  begin
    if (rst)
    begin
      prdata_q <= 32'h0000_0000;
      ovf_seen_q <= 1'b0;
      cf_seen_q <= 2'b00;
    end
    else if (rd_setup)
    begin
      prdata_q <= rd_mux;
      ovf_seen_q <= hit(paddr, `PWMART_IDX_CSR) & overflow_flag_q;
      cf_seen_q[0] <= hit(paddr, `PWMART_IDX_CAPT1) & capture_flags_q[0];
      cf_seen_q[1] <= hit(paddr, `PWMART_IDX_CAPT2) & capture_flags_q[1];
    end
  end

  // Software-written control registers
  always @(posedge clk)
  begin
    if (rst)
    begin
      duty_q[0] <= `PWMART_RST_VAL;
      duty_q[1] <= `PWMART_RST_VAL;
      duty_q[2] <= `PWMART_RST_VAL;
      duty_q[3] <= `PWMART_RST_VAL;
      pwm_output_control_q <= `PWMART_RST_VAL;
      external_clock_select_q <= 1'b0;
      clock_divider_field_q <= 3'h0;
      counter_run_enable_q <= 1'b0;
      overflow_irq_enable_q <= 1'b0;
      reload_value_q <= `PWMART_RST_VAL;
      capture_edge_sel_q <= 2'b00;
      capture_irq_enables_q <= 2'b00;
    end
    else if (wr_acc)
    begin
      if (hit(paddr, `PWMART_IDX_DUTY3))
        duty_q[3] <= pwdata[7:0];
      else if (hit(paddr, `PWMART_IDX_DUTY2))
        duty_q[2] <= pwdata[7:0];
      else if (hit(paddr, `PWMART_IDX_DUTY1))
        duty_q[1] <= pwdata[7:0];
      else if (hit(paddr, `PWMART_IDX_DUTY0))
        duty_q[0] <= pwdata[7:0];
      else if (hit(paddr, `PWMART_IDX_PWMCTL))
        pwm_output_control_q <= pwdata[7:0];
      else if (hit(paddr, `PWMART_IDX_CSR))
      begin
        external_clock_select_q <= pwdata[`PWMART_CSR_EXTERNAL_CLOCK_SELECT];
        clock_divider_field_q <=
          pwdata[`PWMART_CSR_CC_HI:`PWMART_CSR_CC_LO];
        counter_run_enable_q <= pwdata[`PWMART_CSR_TCE];
        overflow_irq_enable_q <= pwdata[`PWMART_CSR_OIE];
      end
      else if (hit(paddr, `PWMART_IDX_ARR))
        reload_value_q <= pwdata[7:0];
      else if (hit(paddr, `PWMART_IDX_ICCSR))
      begin
        capture_edge_sel_q <= pwdata[`PWMART_ICS_CS_HI:`PWMART_ICS_CS_LO];
        capture_irq_enables_q <=
          pwdata[`PWMART_ICS_CIE_HI:`PWMART_ICS_CIE_LO];
      end
    end
  end

  // Prescaler and auto-reload counter
  always @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q <= `PWMART_RST_VAL;
      presc_q <= 7'h00;
    end
    else if (ce)
    begin
      if (car_wr)
      begin
        cnt_q <= pwdata[7:0];
        presc_q <= 7'h00;
      end
      else if (force_reload_wr)
      begin
        cnt_q <= reload_value_q;
        presc_q <= 7'h00;
      end
      else if (counter_run_enable_q & tick)
      begin
        presc_q <= presc_q + 7'h01;
        if (ovf_evt)
          cnt_q <= reload_value_q;
        else if (step)
          cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  // Overflow flag, set wins over read clear
  always @(posedge clk)
  begin
    if (rst)
      overflow_flag_q <= 1'b0;
    else if (ce)
      overflow_flag_q <= ovf_evt | (overflow_flag_q &
        ~(rd_acc & hit(paddr, `PWMART_IDX_CSR) & ovf_seen_q));
  end

  // Pin synchronisers, third stage only for edge detection
  always @(posedge clk)
  begin
    if (rst)
    begin
      ext_sync_q <= 3'b000;
      cap_sync0_q <= 3'b000;
      cap_sync1_q <= 3'b000;
    end
    else if (ce)
    begin
      ext_sync_q <= {ext_sync_q[1:0], ext_clock_pin};
      cap_sync0_q <= {cap_sync0_q[1:0], capture_input_pin[0]};
      cap_sync1_q <= {cap_sync1_q[1:0], capture_input_pin[1]};
    end
  end

  wire [1:0] cap_now = {cap_sync1_q[1], cap_sync0_q[1]};
  wire [1:0] cap_old = {cap_sync1_q[2], cap_sync0_q[2]};

  // Capture channels
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1)
    begin : g_capt
      wire edge_hit = capture_edge_sel_q[c] ?
        (cap_now[c] & ~cap_old[c]) : (~cap_now[c] & cap_old[c]);
      wire cap_evt = edge_hit & ~capture_flags_q[c];
      wire rd_clr = rd_acc & cf_seen_q[c] & hit(paddr,
        c == 0 ? `PWMART_IDX_CAPT1 : `PWMART_IDX_CAPT2);
      always @(posedge clk)
      begin
        if (rst)
        begin
          capture_flags_q[c] <= 1'b0;
          capture_data_q[c] <= `PWMART_RST_VAL;
        end
        else if (ce)
        begin
          capture_flags_q[c] <= cap_evt |
            (capture_flags_q[c] & ~rd_clr);
          if (cap_evt)
            capture_data_q[c] <= cnt_q;
        end
      end
    end
  endgenerate

  // PWM channels
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1)
    begin : g_pwm
      wire pol = pwm_output_control_q[`PWMART_PCR_OP_LO + p];
      wire oe = pwm_output_control_q[`PWMART_PCR_OE_LO + p];
      // Level high from reload up to compare, low past it
      wire raw = (cnt_q <= hidden_compare_q[p]);
      always @(posedge clk)
      begin
        if (rst)
        begin
          hidden_compare_q[p] <= `PWMART_RST_VAL;
          pwm_q[p] <= 1'b0;
        end
        else if (ce)
        begin
          if (ovf_evt)
            hidden_compare_q[p] <= duty_q[p];
          // Polarity applied combinationally to the raw level
          pwm_q[p] <= oe & (raw ^ pol);
        end
      end
    end
  endgenerate

endmodule // pwmart_timer
`default_nettype wire

// ===== sim/pwmart_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwmart_defines.vh"
module pwmart_timer_props
(
  input wire clk,
  input wire rst,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PWMART_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire [3:0] pwm_output_pin,
  input wire [3:0] pwm_pin_drive,
  input wire overflow_irq,
  input wire [1:0] capture_irq
);
  wire acc = psel && penable && ce;
  wire [9:0] ix = paddr[11:2];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_ACCESS: assert property (psel && !penable ##1 acc |-> pready)
    else $error("no ready in access");
  AST_SLVERR: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  AST_FRL_RD: assert property (
    acc && !pwrite && ix == `PWMART_IDX_CSR |-> !prdata[2])
    else $error("force reload reads one");
  AST_RSV_RD: assert property (
    acc && !pwrite && ix == `PWMART_IDX_ICCSR |-> prdata[7:6] == 2'b00)
    else $error("reserved bits nonzero");
  AST_OVF_MASK: assert property (
    acc && pwrite && ix == `PWMART_IDX_CSR && !pwdata[1] |=> !overflow_irq)
    else $error("overflow request not masked");
  AST_CAP_MASK: assert property (
    acc && pwrite && ix == `PWMART_IDX_ICCSR
    |=> (capture_irq & ~$past(pwdata[3:2])) == 2'b00)
    else $error("capture request not masked");
  AST_OE_WR: assert property (
    acc && pwrite && ix == `PWMART_IDX_PWMCTL
    |=> pwm_pin_drive == $past(pwdata[7:4]))
    else $error("output enable not written");
  AST_OE_GATE: assert property (
    (pwm_output_pin & ~$past(pwm_pin_drive)) == 4'h0)
    else $error("disabled channel drives");
  AST_RST_ZERO: assert property ($fell(rst) |-> pwm_pin_drive == 4'h0
    && pwm_output_pin == 4'h0 && !overflow_irq && capture_irq == 2'b00)
    else $error("outputs not zero after reset");
  AST_CAP_CLR: assert property (
    acc && !pwrite && ix == `PWMART_IDX_CAPT1 && capture_irq[0]
    && $past(capture_irq[0]) |=> !capture_irq[0])
    else $error("capture flag not cleared");
  cover property (acc && !pwrite && prdata[0]);
  cover property ($rose(capture_irq[0]));
  cover property ($rose(pwm_output_pin[0]));
endmodule // pwmart_timer_props
bind pwmart_timer pwmart_timer_props u_props (.clk(clk), .rst(rst),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .pwm_output_pin(pwm_output_pin),
  .pwm_pin_drive(pwm_pin_drive), .overflow_irq(overflow_irq),
  .capture_irq(capture_irq));
`default_nettype wire

// ===== sim/pwmart_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pwmart_pin_model
(
  input wire logic clk,
  output logic [1:0] capture_input_pin,
  output logic ext_clock_pin
);
  initial
  begin
    capture_input_pin = 2'b00;
    ext_clock_pin = 1'b0;
  end
  // Move one capture line after an edge
  task automatic drive_cap(input int ch, input logic v);
    @(posedge clk);
    capture_input_pin[ch] <= v;
  endtask
  // Slow pulses on the external count clock
  task automatic pulse_ext(input int n);
    repeat (n)
    begin
      @(posedge clk);
      ext_clock_pin <= 1'b1;
      repeat (3) @(posedge clk);
      ext_clock_pin <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule // pwmart_pin_model
`default_nettype wire

// ===== sim/tb_pwm_autoreload_timer_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwmart_defines.vh"
module tb_pwm_autoreload_timer_regs;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire pready;
  wire pslverr;
  wire ovf_irq;
  wire ext;
  wire [31:0] prdata;
  wire [1:0] cap;
  wire [1:0] cap_irq;
  wire [3:0] pin;
  wire [3:0] drive;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic err;
  pwmart_timer uut (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_clock_pin(ext), .capture_input_pin(cap), .pwm_output_pin(pin),
    .pwm_pin_drive(drive), .overflow_irq(ovf_irq), .capture_irq(cap_irq));
  pwmart_pin_model pins (.clk(clk), .capture_input_pin(cap),
    .ext_clock_pin(ext));
  initial
  begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ix,
    input logic [7:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] ix,
    input logic [31:0] e);
    apb(1'b0, ix, 8'h00);
    chk(nm, e, rd);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_reset;
    for (int i = 8'h73; i <= 8'h7d; i++)
      rchk("reset value", i[7:0], 32'h0);
    rchk("unmapped read", 8'h72, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
  endtask
  task automatic t_count;
    apb(1'b1, `PWMART_IDX_CAR, 8'h10);
    rchk("counter write", `PWMART_IDX_CAR, 32'h10);
    wt(20);
    rchk("counter frozen", `PWMART_IDX_CAR, 32'h10);
    apb(1'b1, `PWMART_IDX_ARR, 8'h20);
    apb(1'b1, `PWMART_IDX_CSR, 8'h0e);
    rchk("force reload bit", `PWMART_IDX_CSR, 32'h0a);
    wt(300);
    chk("overflow request", 32'h1, {31'h0, ovf_irq});
    rchk("overflow flag set", `PWMART_IDX_CSR, 32'h0b);
    rchk("overflow flag clear", `PWMART_IDX_CSR, 32'h0a);
    apb(1'b1, `PWMART_IDX_CSR, 8'h00);
  endtask
  task automatic t_pwm;
    apb(1'b1, `PWMART_IDX_CAR, 8'h05);
    apb(1'b1, `PWMART_IDX_DUTY0, 8'h80);
    apb(1'b1, `PWMART_IDX_PWMCTL, 8'h10);
    wt(2);
    chk("pwm before overflow", 32'h0, {28'h0, pin});
    chk("pin drive", 32'h1, {28'h0, drive});
    apb(1'b1, `PWMART_IDX_PWMCTL, 8'h11);
    wt(2);
    chk("pwm inverted", 32'h1, {28'h0, pin});
  endtask
  task automatic t_cap;
    apb(1'b1, `PWMART_IDX_ICCSR, 8'h14);
    pins.drive_cap(0, 1'b1);
    wt(8);
    chk("capture request", 32'h1, {30'h0, cap_irq});
    rchk("capture one", `PWMART_IDX_CAPT1, 32'h05);
    wt(1);
    chk("capture cleared", 32'h0, {30'h0, cap_irq});
    pins.drive_cap(1, 1'b1);
    wt(8);
    rchk("rise ignored", `PWMART_IDX_ICCSR, 32'h14);
    pins.drive_cap(1, 1'b0);
    wt(8);
    rchk("fall captured", `PWMART_IDX_ICCSR, 32'h16);
    rchk("capture two", `PWMART_IDX_CAPT2, 32'h05);
  endtask
  task automatic t_div;
    apb(1'b1, `PWMART_IDX_CAR, 8'h00);
    apb(1'b1, `PWMART_IDX_CSR, 8'h18);
    wt(20);
    rchk("divide by two", `PWMART_IDX_CAR, 32'h0a);
    apb(1'b1, `PWMART_IDX_CSR, 8'h88);
    apb(1'b1, `PWMART_IDX_CAR, 8'h00);
    pins.pulse_ext(5);
    wt(8);
    rchk("external count", `PWMART_IDX_CAR, 32'h05);
    apb(1'b1, `PWMART_IDX_CSR, 8'h00);
  endtask
  initial
  begin
    #2000000;
    n_mismatch++;
    end_sim();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_count();
    t_pwm();
    t_cap();
    t_div();
    end_sim();
  end
endmodule // tb_pwm_autoreload_timer_regs
`default_nettype wire
